// >>> rtl/adc_config_power_control.sv
`timescale 1ns/1ps

module adc_config_power_control
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serialClk,
    input wire logic csN,
    input wire logic din,
    input wire logic conversionStartN,
    input wire logic conversionDone,
    input wire logic sequenceDone,
    output logic dout,
    output logic analogPowerOn,
    output logic biasPowerOn,
    output logic resultValid,
    output logic softwareConvert,
    output logic referenceDifferential,
    output logic averagingActive,
    output logic [5:0] conversionsPerResult,
    output logic internalClockMode
);
    import adc_cfg_pkg::*;

    core_t s;
    core_t next_s;
    logic [WORD_W-1:0] wordData;
    logic wordToggle;
    logic csRise;
    logic csFall;
    logic cnvFall;
    logic autoOn;
    logic applyWord;
    logic cfgSelect;
    logic nullScan;
    logic wakeReq;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic autoPowerDown(input logic [1:0] pm);
        // unused code behaves as normal mode
        return (pm == PWR_FULL_OFF) || (pm == PWR_BIAS_HOLD);
    endfunction

    function automatic power_state_t downState(input logic [1:0] pm);
        return (pm == PWR_BIAS_HOLD) ? PS_OFF_BIAS : PS_OFF_FULL;
    endfunction

    function automatic logic staticDown(input logic [1:0] static_power_field);
        // reserved static code treated as normal
        return (static_power_field == PWR_FULL_OFF) || (static_power_field == PWR_BIAS_HOLD);
    endfunction

    function automatic logic [5:0] convCount(input logic avg, input logic [1:0] average_count_field);
        return avg ? (AVG_BASE << average_count_field) : SINGLE_CONV;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    serial_frame_link i_serial_frame_link
    (
        .reset_n(reset_n),
        .serialClk(serialClk),
        .csN(csN),
        .din(din),
        .echoEnable(s.cfg.echoEnable),
        .dout(dout),
        .wordData(wordData),
        .wordToggle(wordToggle)
    );

    ////////////////////////////////////////////////////////////////////////////////
    assign csRise = s.csSync & ~s.csPrev;
    assign csFall = ~s.csSync & s.csPrev;
    assign cnvFall = ~s.cnvSync & s.cnvPrev;
    assign autoOn = autoPowerDown(s.mode.automaticPower);
    // word is only taken once the frame has closed
    assign applyWord = (s.togSync != s.togSeen) & s.csSync;
    assign cfgSelect = wordData[CFG_SEL_LSB +: 5] == CFG_SELECT_CODE;
    assign nullScan = wordData[MODE_SCAN_LSB +: 4] >= SCAN_NULL_FIRST;

    always_comb
    begin
        next_s = s;
        wakeReq = 1'b0;
        next_s.csMeta = csN;
        next_s.csSync = s.csMeta;
        next_s.csPrev = s.csSync;
        next_s.cnvMeta = conversionStartN;
        next_s.cnvSync = s.cnvMeta;
        next_s.cnvPrev = s.cnvSync;
        next_s.togMeta = wordToggle;
        next_s.togSync = s.togMeta;
        next_s.softConvert = 1'b0;

        if (applyWord)
        begin
            next_s.togSeen = s.togSync;
            if (!wordData[SEL_MSB])
            begin
                // null scan codes leave the whole mode word ignored
                if (!nullScan)
                begin
                    next_s.mode.scanMode = wordData[MODE_SCAN_LSB +: 4];
                    next_s.mode.internalClock = (wordData[MODE_SCAN_LSB +: 4] == SCAN_UPPER_INT)
                        || (wordData[MODE_SCAN_LSB +: 4] == SCAN_CUSTOM_INT);
                    next_s.mode.automaticPower = wordData[MODE_PM_LSB +: 2];
                    next_s.softConvert = wordData[MODE_SOFTWARE_CONVERT_BIT_BIT];
                    wakeReq = wordData[MODE_SOFTWARE_CONVERT_BIT_BIT] & next_s.mode.internalClock;
                end
            end
            else if (cfgSelect)
            begin
                next_s.cfg.refDifferential = wordData[REFERENCE_SELECT_BIT_BIT];
                next_s.cfg.averagingEnable = wordData[AVG_EN_BIT];
                next_s.cfg.averageCount = wordData[AVERAGE_COUNT_FIELD_LSB +: 2];
                next_s.cfg.staticPower = wordData[SPM_LSB +: 2];
                next_s.cfg.echoEnable = wordData[ECHO_BIT];
            end
        end

        // power state never touches cfg or mode, so nothing is lost while down
        case (s.power)
            PS_ON:
            begin
                if (autoOn && !s.mode.internalClock && csRise)
                begin
                    next_s.power = downState(s.mode.automaticPower);
                end
                else if (autoOn && s.mode.internalClock && sequenceDone)
                begin
                    next_s.power = downState(s.mode.automaticPower);
                end
                else if (s.mode.automaticPower == PWR_FULL_OFF && conversionDone)
                begin
                    next_s.power = PS_OFF_FULL;
                end
            end
            PS_OFF_FULL, PS_OFF_BIAS:
            begin
                if (!autoOn)
                begin
                    next_s.power = PS_ON;
                end
                else if ((!s.mode.internalClock && csFall)
                    || (s.mode.internalClock && (cnvFall || wakeReq)))
                begin
                    next_s.power = PS_WAKE;
                    next_s.discard = WAKE_DISCARD;
                end
            end
            PS_WAKE:
            begin
                // a closing frame or a finished sequence still powers down mid-wake
                if (autoOn && ((!s.mode.internalClock && csRise)
                    || (s.mode.internalClock && sequenceDone)))
                begin
                    next_s.power = downState(s.mode.automaticPower);
                end
                else if (conversionDone)
                begin
                    next_s.discard = s.discard - 2'h1;
                    if (s.discard == 2'h1)
                    begin
                        next_s.power = PS_ON;
                    end
                end
            end
            default:
            begin
                next_s.power = PS_ON;
            end
        endcase

        next_s.analogOn = (next_s.power == PS_ON || next_s.power == PS_WAKE)
            && !staticDown(next_s.cfg.staticPower);
        // partial shutdown, static or automatic, keeps only the bias alive
        next_s.biasOn = (next_s.cfg.staticPower != PWR_FULL_OFF) && (next_s.analogOn
            || next_s.power == PS_OFF_BIAS || next_s.cfg.staticPower == PWR_BIAS_HOLD);
        next_s.resultValid = conversionDone && s.power == PS_ON
            && !staticDown(s.cfg.staticPower);
        // averaging has no meaning with the external clock
        next_s.averagingActive = next_s.cfg.averagingEnable & next_s.mode.internalClock;
        next_s.convPerResult = convCount(next_s.averagingActive, next_s.cfg.averageCount);
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s <= CORE_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign analogPowerOn = s.analogOn;
    assign biasPowerOn = s.biasOn;
    assign resultValid = s.resultValid;
    assign softwareConvert = s.softConvert;
    assign referenceDifferential = s.cfg.refDifferential;
    assign averagingActive = s.averagingActive;
    assign conversionsPerResult = s.convPerResult;
    assign internalClockMode = s.mode.internalClock;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence extDownCause;
        (s.power == PS_ON || s.power == PS_WAKE) && autoOn && !s.mode.internalClock
            && csRise;
    endsequence

    sequence offThenFall;
        (s.power == PS_OFF_FULL || s.power == PS_OFF_BIAS) && autoOn
            && !s.mode.internalClock && csFall;
    endsequence

    sequence wakeDone;
        s.power == PS_WAKE && conversionDone;
    endsequence

    sequence intWakeCause;
        (s.power == PS_OFF_FULL || s.power == PS_OFF_BIAS) && autoOn
            && s.mode.internalClock && (cnvFall || wakeReq);
    endsequence

    AST_MODE_ROUTE: assert property (applyWord && !wordData[SEL_MSB] |=> $stable(s.cfg))
        else $error("mode word changed configuration");
    AST_CFG_ROUTE: assert property (applyWord && wordData[SEL_MSB] |=> $stable(s.mode))
        else $error("configuration word changed mode");
    AST_CFG_SELECT: assert property (applyWord && wordData[SEL_MSB] && cfgSelect
        |=> referenceDifferential == $past(wordData[REFERENCE_SELECT_BIT_BIT])
            && s.cfg.echoEnable == $past(wordData[ECHO_BIT]))
        else $error("configuration fields not taken");
    AST_STATIC_DOWN: assert property (s.cfg.staticPower == PWR_FULL_OFF
        |-> !analogPowerOn && !biasPowerOn)
        else $error("static full shutdown left power on");
    AST_EXT_DOWN: assert property (extDownCause |=> !analogPowerOn
        && biasPowerOn == (($past(s.mode.automaticPower) == PWR_BIAS_HOLD
            || s.cfg.staticPower == PWR_BIAS_HOLD) && s.cfg.staticPower != PWR_FULL_OFF))
        else $error("no power-down at chip-select rise");
    AST_EXT_WAKE: assert property (offThenFall |=> s.power == PS_WAKE
        ##1 s.power == PS_WAKE || s.power == PS_ON)
        else $error("no wake at chip-select fall");
    AST_INT_DOWN: assert property ((s.power == PS_ON || s.power == PS_WAKE)
        && autoOn && s.mode.internalClock
        && sequenceDone |=> s.power == PS_OFF_FULL || s.power == PS_OFF_BIAS)
        else $error("no power-down after sequence end");
    AST_FULL_OFF_EACH: assert property (s.power == PS_ON
        && s.mode.automaticPower == PWR_FULL_OFF && conversionDone |=> s.power == PS_OFF_FULL)
        else $error("no shutdown after conversion");
    AST_WAKE_DISCARD: assert property (wakeDone |=> !resultValid)
        else $error("result flagged valid while waking");
    AST_WAKE_COUNT: assert property (offThenFall |=> s.discard == WAKE_DISCARD)
        else $error("wake discard count wrong");
    AST_RETAIN: assert property (s.power != PS_ON && !applyWord
        |=> $stable(s.cfg) && $stable(s.mode))
        else $error("registers changed while powered down");
    AST_AVG_COUNT: assert property (conversionsPerResult
        == (averagingActive ? (AVG_BASE << s.cfg.averageCount) : SINGLE_CONV))
        else $error("conversions per result wrong");
    AST_UNUSED_PM: assert property (s.power == PS_ON
        && s.mode.automaticPower == PWR_UNUSED |=> s.power == PS_ON)
        else $error("unused automatic code powered down");
    AST_INT_WAKE: assert property (intWakeCause |=> s.power == PS_WAKE)
        else $error("no wake on conversion start");
    AST_NULL_SCAN: assert property (applyWord && !wordData[SEL_MSB] && nullScan
        |=> $stable(s.mode))
        else $error("null scan word changed mode");
    AST_CFG_IGNORE: assert property (applyWord && wordData[SEL_MSB] && !cfgSelect
        |=> $stable(s.cfg))
        else $error("unselected configuration word taken");
    AST_SOFT_CONVERT: assert property (applyWord && !wordData[SEL_MSB] && !nullScan
        |=> softwareConvert == $past(wordData[MODE_SOFTWARE_CONVERT_BIT_BIT]))
        else $error("software convert pulse wrong");
    AST_AUTO_BIAS: assert property (s.power == PS_OFF_BIAS
        && s.cfg.staticPower != PWR_FULL_OFF |-> !analogPowerOn && biasPowerOn)
        else $error("bias hold state powered wrongly");
    AST_AUTO_FULL: assert property (s.power == PS_OFF_FULL
        && s.cfg.staticPower != PWR_BIAS_HOLD |-> !analogPowerOn && !biasPowerOn)
        else $error("full auto off left power on");
    AST_VALID_SOURCE: assert property (resultValid |-> $past(conversionDone))
        else $error("result valid without a conversion");
    AST_SINGLE_CONV: assert property (!averagingActive
        |-> conversionsPerResult == SINGLE_CONV)
        else $error("more than one conversion without averaging");

endmodule // adc_config_power_control

// >>> shared/adc_cfg_pkg.sv
package adc_cfg_pkg;

    localparam int WORD_W = 16;
    localparam int SEL_MSB = 15;
    localparam logic [3:0] LAST_BIT = 4'hF;

    // configuration word layout
    localparam int CFG_SEL_LSB = 11;
    localparam logic [4:0] CFG_SELECT_CODE = 5'h10;
    localparam int REFERENCE_SELECT_BIT_BIT = 10;
    localparam int AVG_EN_BIT = 9;
    localparam int AVERAGE_COUNT_FIELD_LSB = 7;
    localparam int SPM_LSB = 3;
    localparam int ECHO_BIT = 2;

    // mode-control word layout
    localparam int MODE_SCAN_LSB = 11;
    localparam int MODE_PM_LSB = 3;
    localparam int MODE_SOFTWARE_CONVERT_BIT_BIT = 1;

    localparam logic [3:0] SCAN_UPPER_INT = 4'h5;
    localparam logic [3:0] SCAN_CUSTOM_INT = 4'h7;
    localparam logic [3:0] SCAN_NULL_FIRST = 4'hA;

    // shared by the static and automatic power fields
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_FULL_OFF = 2'h1;
    localparam logic [1:0] PWR_BIAS_HOLD = 2'h2;
    localparam logic [1:0] PWR_UNUSED = 2'h3;

    localparam logic [1:0] WAKE_DISCARD = 2'h2;
    localparam logic [5:0] SINGLE_CONV = 6'h01;
    localparam logic [5:0] AVG_BASE = 6'h04;

    typedef enum logic [1:0] {
        PS_ON = 2'b00,
        PS_OFF_FULL = 2'b01,
        PS_OFF_BIAS = 2'b10,
        PS_WAKE = 2'b11
    } power_state_t;

    typedef struct packed {
        logic refDifferential;
        logic averagingEnable;
        logic [1:0] averageCount;
        logic [1:0] staticPower;
        logic echoEnable;
    } config_t;

    typedef struct packed {
        logic [3:0] scanMode;
        logic internalClock;
        logic [1:0] automaticPower;
    } mode_t;

    typedef struct packed {
        logic csMeta;
        logic csSync;
        logic csPrev;
        logic cnvMeta;
        logic cnvSync;
        logic cnvPrev;
        logic togMeta;
        logic togSync;
        logic togSeen;
        config_t cfg;
        mode_t mode;
        power_state_t power;
        logic [1:0] discard;
        logic analogOn;
        logic biasOn;
        logic resultValid;
        logic softConvert;
        logic averagingActive;
        logic [5:0] convPerResult;
    } core_t;

    localparam config_t CONFIG_RESET = 7'h00;
    localparam mode_t MODE_RESET = 7'h00;

    // synchronisers start at the idle pin level, so no false edge follows reset
    localparam core_t CORE_RESET = '{
        csMeta: 1'b1,
        csSync: 1'b1,
        csPrev: 1'b1,
        cnvMeta: 1'b1,
        cnvSync: 1'b1,
        cnvPrev: 1'b1,
        cfg: CONFIG_RESET,
        mode: MODE_RESET,
        power: PS_ON,
        discard: 2'h0,
        analogOn: 1'b1,
        biasOn: 1'b1,
        convPerResult: SINGLE_CONV,
        default: 1'b0
    };

endpackage

// >>> rtl/serial_frame_link.sv
`timescale 1ns/1ps

module serial_frame_link
(
    input wire logic reset_n,
    input wire logic serialClk,
    input wire logic csN,
    input wire logic din,
    input wire logic echoEnable,
    output logic dout,
    output logic [adc_cfg_pkg::WORD_W-1:0] wordData,
    output logic wordToggle
);
    import adc_cfg_pkg::*;

    typedef struct packed {
        logic [3:0] bitCount;
        logic [14:0] shift;
        logic dout;
    } frame_t;

    typedef struct packed {
        logic [15:0] word;
        logic toggle;
        logic echoMeta;
        logic echoSync;
    } held_t;

    frame_t frame;
    frame_t next_frame;
    held_t held;
    held_t next_held;
    logic frameRst_n;

    // serial clock stops between frames, so the frame itself clears the bit position
    assign frameRst_n = reset_n & ~csN;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_frame = frame;
        next_held = held;
        next_held.echoMeta = echoEnable;
        next_held.echoSync = held.echoMeta;
        next_frame.bitCount = frame.bitCount + 4'h1;
        next_frame.shift = {frame.shift[13:0], din};
        // previous frame's word goes back out, msb first
        next_frame.dout = held.echoSync & held.word[LAST_BIT - frame.bitCount];
        if (frame.bitCount == LAST_BIT)
        begin
            // word stays put until the next full frame, so the core can read it safely
            next_held.word = {frame.shift, din};
            next_held.toggle = ~held.toggle;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge serialClk or negedge frameRst_n)
    begin
        if (!frameRst_n)
        begin
            frame <= '0;
        end
        else
        begin
            frame <= next_frame;
        end
    end

    always_ff @(posedge serialClk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            held <= '0;
        end
        else
        begin
            held <= next_held;
        end
    end

    assign dout = frame.dout;
    assign wordData = held.word;
    assign wordToggle = held.toggle;

endmodule // serial_frame_link

// >>> verification/spi_host_model.sv
`timescale 1ns/1ps

module spi_host_model
(
    output logic serialClk,
    output logic csN,
    output logic din,
    input wire logic dout
);

    initial
    begin
        serialClk = 1'b0;
        csN = 1'b1;
        din = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock parked low outside frames; slow stretches setup and hold around the word
    task automatic send(input logic [15:0] w, input bit slow, output logic [15:0] got);
        csN = 1'b0;
        #(slow ? 517.0 : 37.0);
        for (int i = 15; i >= 0; i--)
        begin
            din = w[i];
            #62.5 serialClk = 1'b1;
            #62.5 serialClk = 1'b0;
            got = {got[14:0], dout};
        end
        #(slow ? 300.0 : 40.0) csN = 1'b1;
        // released line: no pull, so show a level the design must not rely on
        din = ~din;
    endtask

    // chip-select without clocks: a frame too short to carry a word
    task automatic select(input logic low);
        csN = low;
        // hold the level long enough for the core to see it before anything moves it
        #100.0;
    endtask

endmodule // spi_host_model

// >>> verification/tb_adc_config_power_control.sv
`timescale 1ns/1ps

module tb_adc_config_power_control;
    import adc_cfg_pkg::*;

    logic clk, reset_n, serialClk, csN, din, conversionStartN, conversionDone, sequenceDone;
    logic dout, analogPowerOn, biasPowerOn, resultValid, softwareConvert;
    logic referenceDifferential, averagingActive, internalClockMode;
    logic [5:0] conversionsPerResult;
    int err_count = 0;
    int total_checks = 0;
    int swCount = 0;
    logic [10:0] stateQ[$];
    logic validQ[$];
    logic doneSeen = 1'b0;
    logic refD = 1'b0;
    logic averaging_enable_bit = 1'b0;
    logic intMode = 1'b0;
    logic [1:0] average_count_field = 2'h0;
    logic [15:0] got;
    logic [15:0] r;
    event snap;

    initial
    begin
        clk = 1'b0;
    end

    always #5 clk = ~clk;

    adc_config_power_control i_adc_config_power_control
    (
        .clk, .reset_n, .serialClk, .csN, .din, .conversionStartN, .conversionDone,
        .sequenceDone, .dout, .analogPowerOn, .biasPowerOn, .resultValid, .softwareConvert,
        .referenceDifferential, .averagingActive, .conversionsPerResult, .internalClockMode
    );

    spi_host_model i_spi_host_model (.serialClk, .csN, .din, .dout);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic report(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask

    task automatic cmp_state(input logic [10:0] e, input logic [10:0] g);
        report("state", {5'h00, e}, {5'h00, g});
    endtask

    task automatic cmp_valid(input logic e, input logic g);
        report("resultValid", {15'h0000, e}, {15'h0000, g});
    endtask

    task automatic cmp_word(input string n, input logic [15:0] e, input logic [15:0] g);
        report(n, e, g);
    endtask

    function automatic logic [15:0] cfgw(logic r1, logic a, logic [1:0] n, logic [1:0] s,
        logic e);
        return {CFG_SELECT_CODE, r1, a, n, 2'h0, s, e, 2'h0};
    endfunction

    function automatic logic [15:0] modew(logic [3:0] sc, logic [1:0] pm, logic sw);
        return {1'b0, sc, 6'h00, pm, 1'b0, sw, 1'b0};
    endfunction

    // order: power, bias, reference, averaging, count, clock mode
    function automatic logic [10:0] expState(logic aon, logic bon);
        logic act;
        act = averaging_enable_bit & intMode;
        return {aon, bon, refD, act, (act ? 6'h04 << average_count_field : 6'h01), intMode};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [15:0] w);
        i_spi_host_model.send(w, 1'($urandom % 2), got);
        // select must stay high a few clocks or the core never sees the frame close
        repeat (6) @(negedge clk);
    endtask

    task automatic cfg(input logic r1, a, input logic [1:0] n, s, input logic e);
        refD = r1;
        averaging_enable_bit = a;
        average_count_field = n;
        wr(cfgw(r1, a, n, s, e));
    endtask

    task automatic mode(input logic [3:0] sc, input logic [1:0] pm, input logic sw);
        intMode = (sc == SCAN_UPPER_INT) || (sc == SCAN_CUSTOM_INT);
        wr(modew(sc, pm, sw));
    endtask

    // apply latency is a few clocks after the select edge; 12 covers it with margin
    task automatic expect_state(input logic aon, input logic bon);
        repeat (12) @(negedge clk);
        stateQ.push_back(expState(aon, bon));
        -> snap;
    endtask

    task automatic conv(input logic e);
        validQ.push_back(e);
        conversionDone = 1'b1;
        @(negedge clk) conversionDone = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic seqdone();
        sequenceDone = 1'b1;
        @(negedge clk) sequenceDone = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always
    begin
        @(snap);
        cmp_state(stateQ.pop_front(), {analogPowerOn, biasPowerOn, referenceDifferential,
            averagingActive, conversionsPerResult, internalClockMode});
    end

    always @(posedge clk)
    begin
        doneSeen <= conversionDone;
    end

    // pulses are looked at half a cycle after the edge that launched them
    always @(negedge clk)
    begin
        if (doneSeen === 1'b1 && validQ.size() > 0)
            cmp_valid(validQ.pop_front(), resultValid);
        if (softwareConvert === 1'b1)
            swCount++;
    end

    initial
    begin
        #500000;
        err_count++;
        stop_test();
    end

    initial
    begin
        reset_n = 1'b0;
        conversionStartN = 1'b1;
        conversionDone = 1'b0;
        sequenceDone = 1'b0;
        void'($urandom(16196));
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        expect_state(1'b1, 1'b1);
        mode(SCAN_UPPER_INT, PWR_NORMAL, 1'b0);
        expect_state(1'b1, 1'b1);
        for (int n = 0; n < 4; n++)
        begin
            cfg(n[0], 1'b1, 2'(n), 2'h0, 1'b0);
            expect_state(1'b1, 1'b1);
        end
        wr({5'h11, 11'h7FF});
        expect_state(1'b1, 1'b1);
        wr(modew(4'hB, PWR_FULL_OFF, 1'b0));
        expect_state(1'b1, 1'b1);
        mode(4'h1, PWR_NORMAL, 1'b0);
        expect_state(1'b1, 1'b1);
        cfg(1'b0, 1'b0, 2'h3, 2'h0, 1'b0);
        mode(SCAN_CUSTOM_INT, PWR_NORMAL, 1'b0);
        expect_state(1'b1, 1'b1);
        for (int s = 0; s < 4; s++)
        begin
            cfg(1'b1, 1'b1, 2'h1, 2'(s), 1'b0);
            expect_state(s == 0 || s == 3, s != 1);
        end
        // echo enable crosses late, so the word echoed is checked one frame on
        cfg(1'b0, 1'b0, 2'h0, 2'h0, 1'b1);
        cfg(1'b1, 1'b0, 2'h2, 2'h0, 1'b1);
        wr(cfgw(1'b1, 1'b0, 2'h2, 2'h0, 1'b0));
        cmp_word("echo", cfgw(1'b1, 1'b0, 2'h2, 2'h0, 1'b1), got);
        wr(cfgw(1'b1, 1'b0, 2'h2, 2'h0, 1'b0));
        wr(cfgw(1'b1, 1'b0, 2'h2, 2'h0, 1'b0));
        cmp_word("echo off", 16'h0000, got);
        mode(4'h1, PWR_BIAS_HOLD, 1'b0);
        expect_state(1'b1, 1'b1);
        wr(modew(4'h1, PWR_BIAS_HOLD, 1'b0));
        expect_state(1'b0, 1'b1);
        i_spi_host_model.select(1'b0);
        expect_state(1'b1, 1'b1);
        conv(1'b0);
        conv(1'b0);
        conv(1'b1);
        i_spi_host_model.select(1'b1);
        expect_state(1'b0, 1'b1);
        mode(4'h1, PWR_FULL_OFF, 1'b0);
        expect_state(1'b0, 1'b1);
        i_spi_host_model.select(1'b0);
        expect_state(1'b1, 1'b1);
        conv(1'b0);
        conv(1'b0);
        conv(1'b1);
        expect_state(1'b0, 1'b0);
        i_spi_host_model.select(1'b1);
        mode(4'h1, PWR_UNUSED, 1'b0);
        expect_state(1'b1, 1'b1);
        mode(SCAN_UPPER_INT, PWR_FULL_OFF, 1'b0);
        seqdone();
        expect_state(1'b0, 1'b0);
        conversionStartN = 1'b0;
        repeat (4) @(negedge clk);
        conversionStartN = 1'b1;
        expect_state(1'b1, 1'b1);
        seqdone();
        expect_state(1'b0, 1'b0);
        mode(SCAN_UPPER_INT, PWR_FULL_OFF, 1'b1);
        expect_state(1'b1, 1'b1);
        cmp_word("softwareConvert", 16'h0001, 16'(swCount));
        repeat (6)
        begin
            r = 16'($urandom);
            cfg(r[0], r[1], r[3:2], 2'h0, 1'b0);
            expect_state(1'b1, 1'b1);
        end
        stop_test();
    end

endmodule // tb_adc_config_power_control
